// File: cssr_consts.svh
`ifndef CSSR_CONSTS_SVH
`define CSSR_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSSR_ADDR_IND 8'h00
`define CSSR_ADDR_RTC 8'h01
`define CSSR_ADDR_PC 8'h02
`define CSSR_ADDR_STAT 8'h03
`define CSSR_ADDR_RSEL 8'h04
`define CSSR_ADDR_CTL 8'h05
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSSR_STAT_T 4
`define CSSR_STAT_P 3
`define CSSR_STAT_Z 2
`define CSSR_STAT_DC 1
`define CSSR_STAT_C 0
`define CSSR_CTL_SRC 5
`define CSSR_CTL_EDGE 4
`define CSSR_CTL_ASSIGN 3
`define CSSR_RSEL_BANK 6
`define CSSR_PAGE_W 10
// ----------------------------------------
// widths, reset values and the status top mask
// ----------------------------------------
`define CSSR_PC_W 12
`define CSSR_STACK_DEPTH 8
`define CSSR_RAM_AW 7
`define CSSR_PC_RST 12'h000
`define CSSR_RTC_RST 8'h00
`define CSSR_RSEL_RST 8'h00
`define CSSR_CTL_RST 8'h00
`define CSSR_STAT_TOP 8'he0
`endif

// File: cssr_pkg.sv
`default_nettype none
package cssr_pkg;
  // one code per instruction class seen by the core registers
  typedef enum logic [3:0] {
    op_seq = 4'h0,
    op_short_jump = 4'h1,
    op_short_call = 4'h2,
    op_long_jump = 4'h3,
    op_long_subroutine = 4'h4,
    op_return = 4'h5,
    op_return_literal = 4'h6,
    op_return_interrupt = 4'h7,
    op_pc_add = 4'h8,
    op_table_read = 4'h9,
    op_sleep = 4'ha,
    op_watchdog_clear = 4'hb
  } cssr_op_e;
  typedef logic [11:0] cssr_addr_t;
endpackage
`default_nettype wire

// File: cssr_ram.sv
`timescale 1ns/1ns
`default_nettype none
module cssr_ram #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // access port
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  if (DW < 1 || AW < 1) begin : g_bad
    $error("cssr_ram: bad geometry");
  end

  typedef struct packed {
    logic [(2**AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } cssr_ram_s;

  cssr_ram_s s_q;
  cssr_ram_s s_d;

  always_comb begin
    s_d = s_q;
    if (wr_en) begin
      s_d.mem[addr] = wdata;
    end
    // read data held until the next read
    if (rd_en) begin
      s_d.rd = s_q.mem[addr];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rd;
endmodule // cssr_ram
`default_nettype wire

// File: cssr_core_regs.sv
`include "cssr_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module cssr_core_regs #(
  parameter int STACK_DEPTH = `CSSR_STACK_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // code option: cycle divider 2/4/8/16
  input wire logic [1:0] cycle_div_sel,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // instruction stream
  input wire logic op_valid,
  input wire cssr_pkg::cssr_op_e op_code,
  input wire cssr_pkg::cssr_addr_t op_target,
  input wire logic [7:0] op_acc,
  output logic op_ready,
  // alu result
  input wire logic alu_valid,
  input wire logic alu_arith,
  input wire logic [7:0] alu_result,
  input wire logic alu_carry7,
  input wire logic alu_carry3,
  // watchdog and pin
  input wire logic wdt_timeout,
  input wire logic realtime_counter_pin,
  // observation
  output logic [11:0] program_counter,
  output logic rtc_wrap,
  output logic carry_flag
);
  import cssr_pkg::*;
  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad
    $error("cssr_core_regs: stack depth must be a power of two");
  end
  typedef struct packed {
    logic [3:0] div;
    logic busy;
    logic [2:0] pin_s;
    logic pin_lvl;
    logic [7:0] presc, rtc;
    logic ovf;
    logic [7:0] ctl;
    logic [`CSSR_PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][`CSSR_PC_W-1:0] stk;
    logic t, p, z, dc, c;
    logic [7:0] rsel, rdata;
    logic ram_sel;
  } cssr_state_s;
  localparam cssr_state_s S_RST = '{
    t: 1'b1, p: 1'b1, pc: `CSSR_PC_RST, rtc: `CSSR_RTC_RST,
    rsel: `CSSR_RSEL_RST, ctl: `CSSR_CTL_RST, default: '0};

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_int_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  // ----------------------------------------
  // decode
  // ----------------------------------------
  cssr_state_s s_q, s_d;
  logic tick, taken, two_cyc;
  logic [3:0] div_mask;
  logic [7:0] rate_mask, ram_rdata;
  logic [`CSSR_PC_W-1:0] pc_next, stack_top;
  logic wr_ind, rd_ind, wr_pc, wr_rtc, wr_stat;
  assign div_mask = 4'((5'h02 << cycle_div_sel) - 5'h01);
  assign tick = (s_q.div & div_mask) == div_mask;
  assign op_ready = tick && !s_q.busy;
  assign taken = op_valid && op_ready;
  assign two_cyc = !(op_code inside {op_seq, op_sleep, op_watchdog_clear});
  assign rate_mask = 8'((9'h002 << s_q.ctl[2:0]) - 9'h001);
  assign pc_next = s_q.pc + 12'h001;
  assign stack_top = s_q.stk[s_q.sp - SP_ONE];
  assign wr_ind = reg_wr && reg_addr == `CSSR_ADDR_IND;
  assign rd_ind = reg_rd && reg_addr == `CSSR_ADDR_IND;
  assign wr_pc = reg_wr && reg_addr == `CSSR_ADDR_PC;
  assign wr_rtc = reg_wr && reg_addr == `CSSR_ADDR_RTC;
  assign wr_stat = reg_wr && reg_addr == `CSSR_ADDR_STAT;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic pin_new, src_ev, cnt_ev;
    pin_new = s_q.pin_lvl;
    src_ev = 1'b0;
    cnt_ev = 1'b0;
    s_d = s_q;
    s_d.div = s_q.div + 4'h1;
    s_d.ovf = 1'b0;
    // pin change accepted only once stages two and three agree
    s_d.pin_s = {s_q.pin_s[1:0], realtime_counter_pin};
    if (s_q.pin_s[1] == s_q.pin_s[2]) begin
      pin_new = s_q.pin_s[2];
    end
    s_d.pin_lvl = pin_new;
    if (s_q.ctl[`CSSR_CTL_SRC]) begin
      src_ev = s_q.ctl[`CSSR_CTL_EDGE] ? (s_q.pin_lvl && !pin_new)
                                       : (!s_q.pin_lvl && pin_new);
    end else begin
      src_ev = tick;
    end
    if (src_ev) begin
      if (!s_q.ctl[`CSSR_CTL_ASSIGN]) begin
        s_d.presc = s_q.presc + 8'h01;
        cnt_ev = (s_q.presc & rate_mask) == rate_mask;
      end else begin
        cnt_ev = 1'b1;
      end
    end
    if (cnt_ev) begin
      s_d.rtc = s_q.rtc + 8'h01;
      s_d.ovf = s_q.rtc == 8'hff;
    end
    if (wr_rtc) begin
      s_d.rtc = reg_wdata;
      s_d.presc = 8'h00;
    end
    // second instruction cycle ends on the next tick
    if (tick && s_q.busy) begin
      s_d.busy = 1'b0;
    end
    if (taken) begin
      s_d.busy = two_cyc;
      unique case (op_code)
        op_seq, op_table_read, op_sleep, op_watchdog_clear: s_d.pc = pc_next;
        op_short_jump: begin
          s_d.pc = {s_q.pc[11:`CSSR_PAGE_W], op_target[`CSSR_PAGE_W-1:0]};
        end
        op_short_call: begin
          s_d.stk[s_q.sp] = pc_next;
          s_d.sp = s_q.sp + SP_ONE;
          s_d.pc = {s_q.pc[11:`CSSR_PAGE_W], op_target[`CSSR_PAGE_W-1:0]};
        end
        op_long_jump: s_d.pc = op_target;
        op_long_subroutine: begin
          s_d.stk[s_q.sp] = pc_next;
          s_d.sp = s_q.sp + SP_ONE;
          s_d.pc = op_target;
        end
        op_return, op_return_literal, op_return_interrupt: begin
          s_d.pc = stack_top;
          s_d.sp = s_q.sp - SP_ONE;
        end
        op_pc_add: s_d.pc = s_q.pc + {4'h0, op_acc};
        default: s_d.pc = pc_next;
      endcase
    end
    if (wr_pc) begin
      s_d.pc = {s_q.pc[11:8], reg_wdata};
      s_d.busy = 1'b1;
    end
    // status bits, set wins over timeout
    if (wdt_timeout) begin
      s_d.t = 1'b0;
    end
    if (taken && op_code == op_sleep) begin
      s_d.t = 1'b1;
      s_d.p = 1'b0;
    end
    if (taken && op_code == op_watchdog_clear) begin
      s_d.t = 1'b1;
      s_d.p = 1'b1;
    end
    if (alu_valid) begin
      s_d.z = alu_result == 8'h00;
      if (alu_arith) begin
        s_d.c = alu_carry7;
        s_d.dc = alu_carry3;
      end
    end
    // software write to flags wins over the alu
    if (wr_stat) begin
      s_d.z = reg_wdata[`CSSR_STAT_Z];
      s_d.dc = reg_wdata[`CSSR_STAT_DC];
      s_d.c = reg_wdata[`CSSR_STAT_C];
    end
    if (reg_wr && reg_addr == `CSSR_ADDR_RSEL) begin
      s_d.rsel = reg_wdata;
    end
    if (reg_wr && reg_addr == `CSSR_ADDR_CTL) begin
      s_d.ctl = reg_wdata;
    end
    // read data stand one cycle only
    s_d.rdata = 8'h00;
    s_d.ram_sel = rd_ind;
    if (reg_rd) begin
      unique case (reg_addr)
        `CSSR_ADDR_RTC: s_d.rdata = s_q.rtc;
        `CSSR_ADDR_PC: s_d.rdata = s_q.pc[7:0];
        `CSSR_ADDR_STAT: begin
          s_d.rdata = {3'b000, s_q.t, s_q.p, s_q.z, s_q.dc, s_q.c};
        end
        `CSSR_ADDR_RSEL: s_d.rdata = s_q.rsel;
        `CSSR_ADDR_CTL: s_d.rdata = s_q.ctl;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // indirect data memory
  // ----------------------------------------
  // alias has no storage
  cssr_ram #(
    .DW(8),
    .AW(`CSSR_RAM_AW)
  ) u_ram (
    .clock(clock),
    .rst_n(rst_int_n),
    .wr_en(wr_ind),
    .rd_en(rd_ind),
    .addr({s_q.rsel[`CSSR_RSEL_BANK], s_q.rsel[5:0]}),
    .wdata(reg_wdata),
    .rdata(ram_rdata)
  );

  assign reg_rdata = s_q.ram_sel ? ram_rdata : s_q.rdata;
  assign program_counter = s_q.pc;
  assign rtc_wrap = s_q.ovf;
  assign carry_flag = s_q.c;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_int_n);

  sequence s_op(cssr_op_e o);
    taken && op_code == o && !wr_pc;
  endsequence
  sequence s_refused_tick;
    ##[0:15] (tick && !op_ready);
  endsequence

  property p_sjump;
    s_op(op_short_jump) |=> program_counter ==
      {$past(s_q.pc[11:10]), $past(op_target[9:0])};
  endproperty
  a_sjump: assert property (p_sjump) else $error("short jump");
  property p_scall;
    s_op(op_short_call) |=> stack_top == $past(pc_next) &&
      program_counter[9:0] == $past(op_target[9:0]);
  endproperty
  a_scall: assert property (p_scall) else $error("short call");
  property p_ljump;
    s_op(op_long_jump) |=> program_counter == $past(op_target);
  endproperty
  a_ljump: assert property (p_ljump) else $error("long jump");
  property p_long_subroutine;
    s_op(op_long_subroutine) |=> stack_top == $past(pc_next)
      && program_counter == $past(op_target);
  endproperty
  a_long_subroutine: assert property (p_long_subroutine) else $error("long call");
  property p_ret;
    s_op(op_return) |=> program_counter == $past(stack_top);
  endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_add;
    s_op(op_pc_add) |=> program_counter ==
      $past(s_q.pc) + {4'h0, $past(op_acc)};
  endproperty
  a_add: assert property (p_add) else $error("relative add");
  property p_pcwr;
    wr_pc |=> program_counter[11:8] == $past(s_q.pc[11:8]) &&
      program_counter[7:0] == $past(reg_wdata);
  endproperty
  a_pcwr: assert property (p_pcwr) else $error("pc write");
  property p_two;
    taken && two_cyc |=> s_refused_tick;
  endproperty
  a_two: assert property (p_two) else $error("two cycles");
  property p_presc;
    wr_rtc |=> s_q.presc == 8'h00 && s_q.rtc == $past(reg_wdata);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler");
  property p_sleep;
    taken && op_code == op_sleep |=> s_q.t && !s_q.p;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags");
  property p_zero;
    alu_valid && alu_result == 8'h00 && !wr_stat |=> s_q.z;
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");
  property p_top;
    reg_rd && reg_addr == `CSSR_ADDR_STAT |=>
      (reg_rdata & `CSSR_STAT_TOP) == 8'h00;
  endproperty
  a_top: assert property (p_top) else $error("status top");
endmodule // cssr_core_regs
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "cssr_consts.svh"
module tb;
  import cssr_pkg::*;
  logic clock, rst_n, reg_wr, reg_rd, op_valid, op_ready, alu_valid;
  logic alu_arith, alu_carry7, alu_carry3, wdt_timeout, realtime_counter_pin;
  logic rtc_wrap, carry_flag;
  logic [1:0] cycle_div_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, op_acc, alu_result;
  cssr_op_e op_code;
  cssr_addr_t op_target;
  logic [11:0] program_counter, m_pc;
  logic [11:0] m_stk [8];
  logic [7:0] m_ram [128];
  logic [4:0] m_stat;
  int error_cnt, total_checks, seed, m_sp, depth;
  cssr_op_e codes [9];

  cssr_core_regs u_dut (
    .clock(clock), .rst_n(rst_n), .cycle_div_sel(cycle_div_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_code(op_code), .op_target(op_target), .op_acc(op_acc),
    .op_ready(op_ready), .alu_valid(alu_valid), .alu_arith(alu_arith),
    .alu_result(alu_result), .alu_carry7(alu_carry7),
    .alu_carry3(alu_carry3), .wdt_timeout(wdt_timeout),
    .realtime_counter_pin(realtime_counter_pin),
    .program_counter(program_counter), .rtc_wrap(rtc_wrap),
    .carry_flag(carry_flag)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk({4'h0, reg_rdata}, {4'h0, e});
  endtask

  // ----------------------------------------
  // instruction stream and its model
  // ----------------------------------------
  function automatic int exp_gap(cssr_op_e c);
    int per;
    per = 2 << cycle_div_sel;
    if (c == op_seq || c == op_sleep || c == op_watchdog_clear) return per;
    return 2 * per;
  endfunction

  task automatic push;
    m_stk[m_sp] = m_pc + 12'h001;
    m_sp = (m_sp + 1) % 8;
  endtask

  task automatic step(input cssr_op_e c, input logic [11:0] t,
                      input logic [7:0] acc);
    case (c)
      op_short_jump: m_pc = {m_pc[11:10], t[9:0]};
      op_short_call: begin
        push();
        m_pc = {m_pc[11:10], t[9:0]};
      end
      op_long_jump: m_pc = t;
      op_long_subroutine: begin
        push();
        m_pc = t;
      end
      op_return, op_return_literal, op_return_interrupt: begin
        m_sp = (m_sp + 7) % 8;
        m_pc = m_stk[m_sp];
      end
      op_pc_add: m_pc = m_pc + {4'h0, acc};
      op_sleep: begin
        m_pc = m_pc + 12'h001;
        m_stat[4:3] = 2'b10;
      end
      op_watchdog_clear: begin
        m_pc = m_pc + 12'h001;
        m_stat[4:3] = 2'b11;
      end
      default: m_pc = m_pc + 12'h001;
    endcase
  endtask

  // gap: clocks from the taking edge until the core is ready again
  task automatic op_chk(input cssr_op_e c, input logic [11:0] t,
                        input logic [7:0] acc, input bit g);
    int n, gap;
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_target <= t;
    op_acc <= acc;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (op_ready !== 1'b1 && n < 64);
    @(posedge clock);
    op_valid <= 1'b0;
    gap = 0;
    do begin
      @(negedge clock);
      gap++;
    end while (op_ready !== 1'b1 && gap < 64);
    step(c, t, acc);
    if (g) chk(12'(gap), 12'(exp_gap(c)));
    chk(program_counter, m_pc);
  endtask

  task automatic alu(input logic [7:0] r, input logic ar, input logic c7,
                     input logic c3);
    @(posedge clock);
    alu_valid <= 1'b1;
    alu_result <= r;
    alu_arith <= ar;
    alu_carry7 <= c7;
    alu_carry3 <= c3;
    @(posedge clock);
    alu_valid <= 1'b0;
    m_stat[2] = (r == 8'h00);
    if (ar) m_stat[1:0] = {c3, c7};
  endtask

  task automatic pin_pulses(input int k);
    repeat (k) begin
      repeat (6) @(posedge clock);
      realtime_counter_pin <= 1'b1;
      repeat (6) @(posedge clock);
      realtime_counter_pin <= 1'b0;
    end
    repeat (8) @(posedge clock);
  endtask

  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] sel, d;
    int k;
    bit seen;
    seed = 32'hb47f398f;
    codes = '{op_seq, op_short_jump, op_short_call, op_long_jump,
              op_long_subroutine, op_return, op_return_literal,
              op_return_interrupt, op_pc_add};
    rst_n = 1'b0;
    {reg_wr, reg_rd, op_valid, alu_valid, alu_arith} = 5'h00;
    {alu_carry7, alu_carry3, wdt_timeout, realtime_counter_pin} = 4'h0;
    cycle_div_sel = 2'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    op_acc = 8'h00;
    alu_result = 8'h00;
    op_code = op_seq;
    op_target = 12'h000;
    m_pc = 12'h000;
    m_sp = 0;
    depth = 0;
    m_stat = 5'b11000;
    repeat (10) @(posedge clock);
    chk(program_counter, 12'h000);
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rdchk(`CSSR_ADDR_STAT, 8'h18);
    // corner cases: page carry on relative add, page kept by short jump
    op_chk(op_long_jump, 12'h3f8, 8'h00, 1'b1);
    op_chk(op_pc_add, 12'h000, 8'h10, 1'b1);
    op_chk(op_long_jump, 12'hc10, 8'h00, 1'b1);
    op_chk(op_short_jump, 12'h5ab, 8'h00, 1'b1);
    op_chk(op_table_read, 12'h000, 8'h00, 1'b1);
    for (int i = 0; i < 40; i++) begin
      k = {$random(seed)} % 9;
      if (k >= 5 && k <= 7 && depth == 0) k = 3;
      if ((k == 2 || k == 4) && depth == 8) k = 1;
      if (k == 2 || k == 4) depth++;
      if (k >= 5 && k <= 7) depth--;
      op_chk(codes[k], 12'($random(seed)), 8'($random(seed)), 1'b1);
    end
    // bus writes to the pc keep the upper bits
    d = 8'($random(seed));
    wr(`CSSR_ADDR_PC, d);
    m_pc = {m_pc[11:8], d};
    rdchk(`CSSR_ADDR_PC, d);
    chk(program_counter, m_pc);
    for (int s = 1; s < 4; s++) begin
      @(posedge clock);
      cycle_div_sel <= 2'(s);
      op_chk(op_seq, 12'h000, 8'h00, 1'b0);
      op_chk(op_seq, 12'h000, 8'h00, 1'b1);
      op_chk(op_long_subroutine, 12'($random(seed)), 8'h00, 1'b1);
      op_chk(op_return, 12'h000, 8'h00, 1'b1);
    end
    @(posedge clock);
    cycle_div_sel <= 2'h0;
    // status flags from alu, sleep, watchdog
    for (int i = 0; i < 8; i++) begin
      d = (i % 3 == 0) ? 8'h00 : 8'($random(seed));
      alu(d, 1'(i % 2), 1'($random(seed)), 1'($random(seed)));
      rdchk(`CSSR_ADDR_STAT, {3'h0, m_stat});
      chk({11'h0, carry_flag}, {11'h0, m_stat[0]});
    end
    op_chk(op_sleep, 12'h000, 8'h00, 1'b1);
    rdchk(`CSSR_ADDR_STAT, {3'h0, m_stat});
    @(posedge clock);
    wdt_timeout <= 1'b1;
    @(posedge clock);
    wdt_timeout <= 1'b0;
    m_stat[4] = 1'b0;
    rdchk(`CSSR_ADDR_STAT, {3'h0, m_stat});
    op_chk(op_watchdog_clear, 12'h000, 8'h00, 1'b1);
    wr(`CSSR_ADDR_STAT, 8'hff);
    m_stat[2:0] = 3'b111;
    rdchk(`CSSR_ADDR_STAT, {3'h0, m_stat});
    wr(8'h30, 8'h5c);
    rdchk(8'h30, 8'h00);
    // indirect access through the select register, both banks
    for (int i = 0; i < 16; i++) begin
      sel = (i == 0) ? 8'h05 : (i == 1) ? 8'h45 : 8'($random(seed));
      d = 8'($random(seed));
      wr(`CSSR_ADDR_RSEL, sel);
      wr(`CSSR_ADDR_IND, d);
      m_ram[sel[6:0]] = d;
    end
    for (int i = 0; i < 128; i += 9) begin
      sel = {$random(seed)} % 2 == 0 ? {1'b0, 7'(i)} : {1'b1, 7'(i)};
      wr(`CSSR_ADDR_RSEL, sel);
      rdchk(`CSSR_ADDR_RSEL, sel);
      d = (m_ram[7'(i)] === 8'hxx) ? 8'h00 : m_ram[7'(i)];
      rdchk(`CSSR_ADDR_IND, d);
    end
    // same offset in both banks, only the bank bit tells them apart
    wr(`CSSR_ADDR_RSEL, 8'h85);
    rdchk(`CSSR_ADDR_IND, m_ram[7'h05]);
    wr(`CSSR_ADDR_RSEL, 8'h45);
    rdchk(`CSSR_ADDR_IND, m_ram[7'h45]);
    // prescaler at /256 in front of the counter
    wr(`CSSR_ADDR_CTL, 8'h07);
    wr(`CSSR_ADDR_RTC, 8'h40);
    rdchk(`CSSR_ADDR_RTC, 8'h40);
    repeat (690) @(posedge clock);
    rdchk(`CSSR_ADDR_RTC, 8'h41);
    wr(`CSSR_ADDR_CTL, 8'h08);
    wr(`CSSR_ADDR_RTC, 8'hfe);
    seen = 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(negedge clock);
      if (rtc_wrap === 1'b1) seen = 1'b1;
    end
    chk({11'h0, seen}, 12'h001);
    // pin as source, rising then falling edges
    wr(`CSSR_ADDR_CTL, 8'h28);
    wr(`CSSR_ADDR_RTC, 8'h10);
    pin_pulses(3);
    rdchk(`CSSR_ADDR_RTC, 8'h13);
    wr(`CSSR_ADDR_CTL, 8'h38);
    wr(`CSSR_ADDR_RTC, 8'h20);
    pin_pulses(2);
    rdchk(`CSSR_ADDR_RTC, 8'h22);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
